// file: logic/gtcc_top.v
// gated 16-bit counter, period timer and two capture/compare units
// Functional notes
// [R1] 16-bit up-counter, readable and writable as high and low bytes.
// [R2] counts instruction clock or external clock, after 3-bit prescaler.
// [R3] synchronous or asynchronous operation chosen by a setting.
// [R4] counts only while the selected gate source allows it.
// [R5] gate active level is programmable high or low.
// [R6] gate toggle, single pulse, gate value and gate event flag.
// [R7] overflow flag on all-ones to zero, interrupt when enabled.
// [R8] overflow wakes from sleep only with external clock, async mode.
// [R9] gated counter is the common time base of both units.
// [R10] capture latches the count on the unit's input event.
// [R11] compare drives the unit output when the count matches.
// [R12] pwm output with programmable period and duty from period timer.
// [R13] both pwm units share one period and one update event.
// [R14] both pwm outputs rise on the same clock cycle.
// [R15] special trigger of one unit clears the counter for the other.
// [R16] special trigger match clears counter and pulses a trigger out.
// [R17] a pwm unit has no counter interaction with the other unit.
// [R18] external clock passes two flip-flops before touching the count.
`include "gtcc_consts.vh"

module gtcc_top (
  // clock and reset
  input wire clk,
  input wire resetn,
  // power state
  input wire sleep,
  // counter clock configuration
  input wire counter_on,
  input wire clk_src_ext,
  input wire async_mode,
  input wire [2:0] prescale_sel,
  input wire ext_count_clk,
  // gate configuration and sources
  input wire gate_enable,
  input wire gate_polarity,
  input wire gate_toggle,
  input wire gate_single_pulse,
  input wire gate_go,
  input wire [1:0] gate_src_sel,
  input wire [3:0] gate_src_in,
  input wire gate_event_clr,
  input wire gate_event_irq_enable,
  // counter access
  input wire count_wr_high,
  input wire count_wr_low,
  input wire [7:0] count_wr_data,
  // overflow control
  input wire overflow_clr,
  input wire overflow_irq_enable,
  // period timer
  input wire period_timer_on,
  input wire [7:0] period_value,
  // unit a
  input wire [2:0] unit_a_mode,
  input wire [15:0] unit_a_cmp_value,
  input wire [7:0] unit_a_duty,
  input wire unit_a_in,
  input wire unit_a_flag_clr,
  // unit b
  input wire [2:0] unit_b_mode,
  input wire [15:0] unit_b_cmp_value,
  input wire [7:0] unit_b_duty,
  input wire unit_b_in,
  input wire unit_b_flag_clr,
  // counter state
  output wire [7:0] gated_count_high,
  output wire [7:0] gated_count_low,
  output reg overflow_flag,
  output wire overflow_irq,
  output reg wake_req,
  // gate state
  output reg gate_value,
  output wire gate_busy,
  output reg gate_event_flag,
  output wire gate_event_irq,
  // period timer state
  output reg [7:0] period_count,
  output reg period_update,
  // unit a results
  output wire [15:0] unit_a_value_pair,
  output wire unit_a_flag,
  output wire unit_a_out,
  // unit b results
  output wire [15:0] unit_b_value_pair,
  output wire unit_b_flag,
  output wire unit_b_out,
  // special trigger to other modules
  output wire special_trigger
);

  localparam SP_IDLE = `GTCC_SP_IDLE;
  localparam SP_ARMED = `GTCC_SP_ARMED;
  localparam SP_OPEN = `GTCC_SP_OPEN;

  reg rst_s1_r;
  reg rst_n_r;
  reg ext_s1_r;
  reg ext_s2_r;
  reg ext_s3_r;
  reg [1:0] instr_div_r;
  reg [`GTCC_PSC_W-1:0] psc_r;
  reg [15:0] gated_counter_r;
  reg [15:0] count_nxt;
  reg count_upd_r;
  reg gate_act_r;
  reg gate_act_d_r;
  reg tog_r;
  reg gate_value_d_r;
  reg [2:0] sp_state_r;
  reg [2:0] sp_state_nxt;
  wire trig_a;
  wire trig_b;

  // reset release through two flip-flops
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // external count clock resynchronised, edge found after the second flop
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= ext_count_clk; // [R18]
      ext_s2_r <= ext_s1_r; // [R18]
      ext_s3_r <= ext_s2_r;
    end
  end

  wire ext_rise = ext_s2_r & ~ext_s3_r;

  // instruction clock enable, halted while asleep
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      instr_div_r <= 2'h0;
    end else if (!sleep) begin
      instr_div_r <= instr_div_r + 2'h1;
    end
  end

  wire instr_tick = ~sleep & (instr_div_r == `GTCC_INSTR_DIV);

  // sync mode stops in sleep with the system clock; async keeps counting
  wire ext_tick = ext_rise & (async_mode | ~sleep); // [R3]
  wire src_tick = clk_src_ext ? ext_tick : instr_tick; // [R2]

  // gate source selection and polarity
  wire gate_src = gate_src_in[gate_src_sel]; // [R4]
  wire gate_act = gate_polarity ? gate_src : ~gate_src; // [R5]
  wire gate_rise = gate_act_r & ~gate_act_d_r;
  wire gate_stage = gate_toggle ? tog_r : gate_act_r;
  wire gv_rise = gate_value & ~gate_value_d_r;
  wire gv_fall = ~gate_value & gate_value_d_r;

  // gate sampling and toggle flip-flop
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      gate_act_r <= 1'b0;
      gate_act_d_r <= 1'b0;
      tog_r <= 1'b0;
      gate_value <= 1'b0;
      gate_value_d_r <= 1'b0;
    end else begin
      gate_act_r <= gate_act;
      gate_act_d_r <= gate_act_r;
      if (!gate_toggle) begin
        tog_r <= 1'b0;
      end else if (gate_rise) begin
        tog_r <= ~tog_r; // [R6]
      end
      gate_value <= gate_stage; // [R6]
      gate_value_d_r <= gate_value;
    end
  end

  // gate single-pulse sequence: armed by go, one high gate period
  always @* begin
    sp_state_nxt = sp_state_r;
    case (sp_state_r)
      SP_IDLE: begin
        if (gate_single_pulse && gate_go) begin
          sp_state_nxt = SP_ARMED;
        end
      end
      SP_ARMED: begin
        if (!gate_single_pulse) begin
          sp_state_nxt = SP_IDLE;
        end else if (gv_rise) begin
          sp_state_nxt = SP_OPEN; // [R6]
        end
      end
      SP_OPEN: begin
        if (!gate_single_pulse || gv_fall) begin
          sp_state_nxt = SP_IDLE; // [R6]
        end
      end
      default: begin
        sp_state_nxt = SP_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sp_state_r <= SP_IDLE;
    end else begin
      sp_state_r <= sp_state_nxt;
    end
  end

  assign gate_busy = (sp_state_r != SP_IDLE);

  // a gate period ended: end of single pulse, or any falling gate
  wire gate_evt = gate_single_pulse ? (sp_state_r == SP_OPEN) & gv_fall
                                    : gv_fall;

  // gate event flag, set wins over clear
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      gate_event_flag <= 1'b0;
    end else if (gate_enable && gate_evt) begin
      gate_event_flag <= 1'b1; // [R6]
    end else if (gate_event_clr) begin
      gate_event_flag <= 1'b0;
    end
  end

  assign gate_event_irq = gate_event_flag & gate_event_irq_enable; // [R6]

  // counting is allowed while on and the gate is open
  wire gate_open = ~gate_enable |
                   (gate_single_pulse ? (sp_state_r == SP_OPEN)
                                      : gate_value); // [R4]
  wire run = counter_on & gate_open;

  // prescaler: divide by two to the power of the 3-bit selection
  wire [7:0] psc_span = 8'h01 << prescale_sel;
  wire [7:0] psc_lim = psc_span - 8'h01;
  wire psc_last = ({1'b0, psc_r} == psc_lim);
  wire sw_wr = count_wr_high | count_wr_low;

  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      psc_r <= {`GTCC_PSC_W{1'b0}};
    end else if (sw_wr) begin
      psc_r <= {`GTCC_PSC_W{1'b0}};
    end else if (run && src_tick) begin
      if (psc_last) begin
        psc_r <= {`GTCC_PSC_W{1'b0}};
      end else begin
        psc_r <= psc_r + 7'h01; // [R2]
      end
    end
  end

  wire count_tick = run & src_tick & psc_last;
  // only special trigger mode clears the counter; compare mode does not
  wire clr_req = trig_a | trig_b; // [R15] [R17]
  wire ovf_evt = count_tick & ~clr_req & ~sw_wr &
                 (gated_counter_r == `GTCC_COUNT_ALL1);

  // counter next value: clear, then software write, then count
  always @* begin
    count_nxt = gated_counter_r;
    if (clr_req) begin
      count_nxt = `GTCC_COUNT_RST; // [R15] [R16]
    end else if (sw_wr) begin
      if (count_wr_high) begin
        count_nxt[15:8] = count_wr_data; // [R1]
      end
      if (count_wr_low) begin
        count_nxt[7:0] = count_wr_data; // [R1]
      end
    end else if (count_tick) begin
      count_nxt = gated_counter_r + 16'h0001; // [R1]
    end
  end

  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      gated_counter_r <= `GTCC_COUNT_RST;
      count_upd_r <= 1'b0;
    end else begin
      gated_counter_r <= count_nxt;
      count_upd_r <= count_tick & ~clr_req & ~sw_wr;
    end
  end

  assign gated_count_high = gated_counter_r[15:8];
  assign gated_count_low = gated_counter_r[7:0];

  // overflow flag, set wins over clear, and wake request
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      overflow_flag <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      if (ovf_evt) begin
        overflow_flag <= 1'b1; // [R7]
      end else if (overflow_clr) begin
        overflow_flag <= 1'b0;
      end
      wake_req <= ovf_evt & sleep & clk_src_ext & async_mode; // [R8]
    end
  end

  assign overflow_irq = overflow_flag & overflow_irq_enable; // [R7]

  // period timer: wraps after the period value, one shared update
  wire pt_wrap = period_timer_on & (period_count == period_value);
  wire [7:0] pt_nxt = !period_timer_on ? period_count :
                      pt_wrap ? `GTCC_PT_RST : period_count + 8'h01;

  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      period_count <= `GTCC_PT_RST;
      period_update <= 1'b0;
    end else begin
      period_count <= pt_nxt; // [R12]
      period_update <= pt_wrap; // [R13]
    end
  end

  // both units see the same count and the same period timer
  gtcc_unit u_unit_a (
    .clk(clk),
    .rst_n(rst_n_r),
    .mode(unit_a_mode),
    .cmp_value(unit_a_cmp_value),
    .pwm_duty(unit_a_duty),
    .count(gated_counter_r), // [R9]
    .count_upd(count_upd_r),
    .pt_nxt(pt_nxt),
    .pwm_update(pt_wrap), // [R13]
    .event_in(unit_a_in),
    .event_clr(unit_a_flag_clr),
    .unit_value_pair(unit_a_value_pair),
    .event_flag(unit_a_flag),
    .unit_out(unit_a_out),
    .trig(trig_a)
  );

  gtcc_unit u_unit_b (
    .clk(clk),
    .rst_n(rst_n_r),
    .mode(unit_b_mode),
    .cmp_value(unit_b_cmp_value),
    .pwm_duty(unit_b_duty),
    .count(gated_counter_r), // [R9]
    .count_upd(count_upd_r),
    .pt_nxt(pt_nxt),
    .pwm_update(pt_wrap), // [R13]
    .event_in(unit_b_in),
    .event_clr(unit_b_flag_clr),
    .unit_value_pair(unit_b_value_pair),
    .event_flag(unit_b_flag),
    .unit_out(unit_b_out),
    .trig(trig_b)
  );

  assign special_trigger = trig_a | trig_b; // [R16]

endmodule

// file: common/gtcc_consts.vh
// shared constants of the gated timer with two capture/compare units
`ifndef GTCC_CONSTS_VH
`define GTCC_CONSTS_VH

// unit mode codes (3-bit mode field per unit)
`define GTCC_MODE_OFF 3'h0
`define GTCC_MODE_CAPTURE 3'h1
`define GTCC_MODE_COMPARE 3'h2
`define GTCC_MODE_SPECIAL 3'h3
`define GTCC_MODE_PWM 3'h4

// widths
`define GTCC_COUNT_W 16
`define GTCC_PSC_W 7
`define GTCC_PT_W 8

// reset values and the all-ones overflow count
`define GTCC_COUNT_RST 16'h0000
`define GTCC_PT_RST 8'h00
`define GTCC_COUNT_ALL1 16'hffff

// instruction clock ticks when the 2-bit divider reaches this count, one system clock in four
`define GTCC_INSTR_DIV 2'h3

// gate single-pulse state codes, one-hot
`define GTCC_SP_IDLE 3'h1
`define GTCC_SP_ARMED 3'h2
`define GTCC_SP_OPEN 3'h4

`endif

// file: logic/gtcc_unit.v
// one capture/compare/pwm unit driven by the shared time bases
`include "gtcc_consts.vh"

module gtcc_unit (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // configuration
  input wire [2:0] mode,
  input wire [15:0] cmp_value,
  input wire [7:0] pwm_duty,
  // shared time bases
  input wire [15:0] count,
  input wire count_upd,
  input wire [7:0] pt_nxt,
  input wire pwm_update,
  // capture input and event flag clear
  input wire event_in,
  input wire event_clr,
  // results
  output reg [15:0] unit_value_pair,
  output reg event_flag,
  output reg unit_out,
  output reg trig
);

  reg event_in_r;
  reg [7:0] duty_l_r;
  wire is_cap = (mode == `GTCC_MODE_CAPTURE);
  wire is_cmp = (mode == `GTCC_MODE_COMPARE);
  wire is_sp = (mode == `GTCC_MODE_SPECIAL);
  wire is_pwm = (mode == `GTCC_MODE_PWM);
  wire cap_hit = is_cap & event_in & ~event_in_r;
  // match only once, on the cycle after the count stepped onto the value
  wire cmp_hit = (is_cmp | is_sp) & count_upd & (count == cmp_value);
  wire [7:0] duty_nxt = pwm_update ? pwm_duty : duty_l_r;

  // capture latch, compare output and special trigger
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      event_in_r <= 1'b0;
      unit_value_pair <= `GTCC_COUNT_RST;
      event_flag <= 1'b0;
      unit_out <= 1'b0;
      trig <= 1'b0;
      duty_l_r <= 8'h00;
    end else begin
      event_in_r <= event_in;
      if (cap_hit) begin
        unit_value_pair <= count; // [R10]
      end
      // set wins over the clear
      if (cap_hit | cmp_hit) begin
        event_flag <= 1'b1;
      end else if (event_clr) begin
        event_flag <= 1'b0;
      end
      trig <= is_sp & cmp_hit; // [R16]
      duty_l_r <= duty_nxt; // [R13]
      if (is_pwm) begin
        unit_out <= pt_nxt < duty_nxt; // [R12] [R14]
      end else if (is_cmp) begin
        if (cmp_hit) begin
          unit_out <= 1'b1; // [R11]
        end
      end else begin
        unit_out <= 1'b0;
      end
    end
  end

endmodule

// file: bench/gtcc_top_assertions.sv
// concurrent checks on the gated timer top ports
`include "gtcc_consts.vh"
module gtcc_top_chk (
  // clock and reset
  input logic clk,
  input logic resetn,
  // configuration seen by the checks
  input logic clk_src_ext,
  input logic async_mode,
  input logic count_wr_high,
  input logic count_wr_low,
  input logic overflow_irq_enable,
  input logic gate_event_irq_enable,
  input logic [2:0] unit_a_mode,
  input logic [2:0] unit_b_mode,
  input logic [7:0] unit_a_duty,
  input logic [7:0] unit_b_duty,
  // outputs under check
  input logic [7:0] gated_count_high,
  input logic [7:0] gated_count_low,
  input logic overflow_flag,
  input logic overflow_irq,
  input logic wake_req,
  input logic gate_event_flag,
  input logic gate_event_irq,
  input logic unit_a_out,
  input logic unit_b_out,
  input logic special_trigger
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // full count and both-pwm condition
  logic [15:0] cnt;
  logic pwm2;
  assign cnt = {gated_count_high, gated_count_low};
  assign pwm2 = unit_a_mode == `GTCC_MODE_PWM &&
    unit_b_mode == `GTCC_MODE_PWM;
  // no write and no clear pending
  sequence quiet;
    !count_wr_high && !count_wr_low && !special_trigger;
  endsequence
  // both units in pwm with settled duties
  sequence pwm_steady;
    pwm2 && $stable(unit_a_duty) && $stable(unit_b_duty);
  endsequence
  AST_STEP: assert property (quiet ##1 quiet ##1 cnt != $past(cnt)
    |-> cnt == 16'($past(cnt) + 16'h0001)) else $error("count jumped");
  AST_OVF_SET: assert property (
    quiet ##1 (quiet and cnt == `GTCC_COUNT_ALL1) ##1 cnt == 16'h0000
    |-> ##[0:1] overflow_flag) else $error("no overflow flag on wrap");
  AST_OVF_IRQ: assert property (
    overflow_irq == (overflow_flag && overflow_irq_enable))
    else $error("overflow irq mask wrong");
  AST_GATE_IRQ: assert property (
    gate_event_irq == (gate_event_flag && gate_event_irq_enable))
    else $error("gate irq mask wrong");
  AST_WAKE: assert property (
    wake_req |-> overflow_flag && clk_src_ext && async_mode)
    else $error("wake outside async external overflow");
  AST_TRIG_PULSE: assert property (
    special_trigger |=> !special_trigger)
    else $error("trigger longer than one cycle");
  AST_TRIG_CLR: assert property (
    special_trigger |-> ##[0:1] cnt == 16'h0000)
    else $error("trigger did not clear count");
  AST_PWM_ALIGN: assert property (
    pwm_steady ##1 (pwm_steady and $rose(unit_a_out))
    |-> unit_b_out || unit_b_duty == 8'h00)
    else $error("pwm rising edges not aligned");
  AST_CMP_HOLD: assert property (
    unit_a_mode == `GTCC_MODE_COMPARE && $past(unit_a_out) &&
    $past(unit_a_mode) == `GTCC_MODE_COMPARE |-> unit_a_out)
    else $error("compare output dropped");
endmodule

bind gtcc_top gtcc_top_chk chk (.*);

// file: bench/gtcc_top_tb_top.sv
// self-checking bench for the gated timer top
`include "gtcc_consts.vh"
module gtcc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // clock, reset and stimulus
  logic clk = 0, resetn = 0, sleep = 0, counter_on = 0, clk_src_ext = 0;
  logic async_mode = 0, ext_count_clk = 0, gate_enable = 0;
  logic gate_polarity = 0, gate_toggle = 0, gate_single_pulse = 0;
  logic gate_go = 0, gate_event_clr = 0, gate_event_irq_enable = 0;
  logic count_wr_high = 0, count_wr_low = 0, overflow_clr = 0;
  logic overflow_irq_enable = 0, period_timer_on = 0, unit_a_in = 0;
  logic unit_a_flag_clr = 0, unit_b_in = 0, unit_b_flag_clr = 0;
  logic [2:0] prescale_sel = 0, unit_a_mode = 0, unit_b_mode = 0;
  logic [1:0] gate_src_sel = 0;
  logic [3:0] gate_src_in = 0;
  logic [7:0] count_wr_data = 0, period_value = 0;
  logic [7:0] unit_a_duty = 0, unit_b_duty = 0;
  logic [15:0] unit_a_cmp_value = 0, unit_b_cmp_value = 0;
  // design outputs
  logic [7:0] gated_count_high, gated_count_low, period_count;
  logic overflow_flag, overflow_irq, wake_req, gate_value, gate_busy;
  logic gate_event_flag, gate_event_irq, period_update, unit_a_flag;
  logic unit_a_out, unit_b_flag, unit_b_out, special_trigger;
  logic [15:0] unit_a_value_pair, unit_b_value_pair;
  wire [15:0] cnt = {gated_count_high, gated_count_low};
  int mismatches = 0, num_checks = 0, n, ha, hb, wakes = 0;
  gtcc_top uut (.*);
  // clock and wake pulse tally
  initial forever #10 clk = ~clk;
  always @(posedge clk) wakes += (wake_req === 1'b1);
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // bounded wait for a flag or pulse
  task automatic await(ref logic s);
    n = 0;
    while (s !== 1'b1 && n < 3000) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic wr_count(input logic [15:0] v);
    count_wr_data = v[15:8];
    count_wr_high = 1;
    cyc(1);
    count_wr_data = v[7:0];
    count_wr_high = 0;
    count_wr_low = 1;
    cyc(1);
    count_wr_low = 0;
    cyc(3);
  endtask
  // overflow near all ones, then prescaled rate
  task automatic t_count();
    wr_count(16'hfffc);
    chk(cnt, 16'hfffc);
    overflow_irq_enable = 1;
    counter_on = 1;
    await(overflow_flag);
    chk(overflow_irq, 1);
    chk(cnt < 16'h0002, 1);
    counter_on = 0;
    overflow_clr = 1;
    cyc(1);
    overflow_clr = 0;
    cyc(2);
    chk(overflow_flag, 0);
    wr_count(16'h0000);
    prescale_sel = 3'h2;
    counter_on = 1;
    cyc(160);
    counter_on = 0;
    chk(cnt >= 16'h0009 && cnt <= 16'h000b, 1);
    prescale_sel = 3'h0;
  endtask
  // one high pulse on gate source 1
  task automatic src_pulse();
    gate_src_in = 4'h2;
    cyc(4);
    gate_src_in = 4'h0;
    cyc(4);
  endtask
  // gate level, polarity, toggle and single pulse
  task automatic t_gate();
    gate_enable = 1;
    gate_polarity = 1;
    gate_src_sel = 2'h1;
    cyc(4);
    gate_event_clr = 1;
    cyc(1);
    gate_event_clr = 0;
    wr_count(16'h0000);
    counter_on = 1;
    cyc(40);
    chk(cnt, 16'h0000);
    chk(gate_event_flag, 0);
    gate_polarity = 0;
    cyc(3);
    chk(gate_value, 1);
    cyc(40);
    chk(cnt != 16'h0000, 1);
    counter_on = 0;
    gate_polarity = 1;
    gate_event_irq_enable = 1;
    src_pulse();
    chk(gate_event_irq, 1);
    gate_toggle = 1;
    src_pulse();
    chk(gate_value, 1);
    gate_toggle = 0;
    cyc(4);
    gate_event_clr = 1;
    cyc(1);
    gate_event_clr = 0;
    cyc(1);
    chk(gate_event_flag, 0);
    gate_single_pulse = 1;
    gate_go = 1;
    cyc(1);
    gate_go = 0;
    chk(gate_busy, 1);
    src_pulse();
    chk(gate_busy, 0);
    chk(gate_event_flag, 1);
    gate_single_pulse = 0;
    gate_enable = 0;
  endtask
  // both units capture one frozen count
  task automatic t_capture();
    wr_count(16'h1234);
    unit_a_mode = `GTCC_MODE_CAPTURE;
    unit_b_mode = `GTCC_MODE_CAPTURE;
    cyc(2);
    unit_a_in = 1;
    unit_b_in = 1;
    cyc(4);
    unit_a_in = 0;
    unit_b_in = 0;
    chk(unit_a_value_pair, 16'h1234);
    chk(unit_b_value_pair, 16'h1234);
    chk(unit_a_flag, 1);
    chk(unit_b_flag, 1);
    unit_a_flag_clr = 1;
    cyc(1);
    unit_a_flag_clr = 0;
    cyc(1);
    chk(unit_a_flag, 0);
  endtask
  // compare match, then special trigger clears the count
  task automatic t_special();
    unit_a_mode = `GTCC_MODE_COMPARE;
    unit_a_cmp_value = 16'h0004;
    unit_b_mode = `GTCC_MODE_SPECIAL;
    unit_b_cmp_value = 16'h0008;
    wr_count(16'h0000);
    counter_on = 1;
    await(unit_a_out);
    chk(unit_a_out, 1);
    await(special_trigger);
    chk(special_trigger, 1);
    cyc(1);
    chk(cnt < 16'h0002, 1);
    unit_a_mode = `GTCC_MODE_CAPTURE;
    unit_a_in = 1;
    cyc(4);
    unit_a_in = 0;
    chk(unit_a_value_pair < 16'h0004, 1);
    counter_on = 0;
  endtask
  // two pwm units on one period timer
  task automatic t_pwm();
    unit_a_mode = `GTCC_MODE_PWM;
    unit_b_mode = `GTCC_MODE_PWM;
    period_value = 8'h03;
    unit_a_duty = 8'h02;
    unit_b_duty = 8'h01;
    period_timer_on = 1;
    await(period_update);
    cyc(4);
    ha = 0;
    hb = 0;
    n = 0;
    repeat (8) begin
      cyc(1);
      ha += unit_a_out;
      hb += unit_b_out;
      n += period_update;
      if (period_update === 1'b1) chk(period_count, 16'h0000);
    end
    chk(16'(ha), 16'h0004);
    chk(16'(hb), 16'h0002);
    chk(16'(n), 16'h0002);
    period_timer_on = 0;
    unit_a_mode = `GTCC_MODE_OFF;
    unit_b_mode = `GTCC_MODE_OFF;
  endtask
  // external clock counted in sleep only when asynchronous
  task automatic t_async();
    wr_count(16'hfffe);
    clk_src_ext = 1;
    async_mode = 1;
    sleep = 1;
    counter_on = 1;
    repeat (4) begin
      ext_count_clk = 1;
      cyc(7);
      ext_count_clk = 0;
      cyc(7);
    end
    chk(cnt, 16'h0002);
    chk(16'(wakes), 16'h0001);
    async_mode = 0;
    repeat (2) begin
      ext_count_clk = 1;
      cyc(7);
      ext_count_clk = 0;
      cyc(7);
    end
    chk(cnt, 16'h0002);
    sleep = 0;
    counter_on = 0;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #1_000_000;
    mismatches++;
    complete_run();
  end
  // main sequence
  initial begin
    cyc(5);
    resetn = 1;
    cyc(3);
    chk(cnt, `GTCC_COUNT_RST);
    t_count();
    t_gate();
    t_capture();
    t_special();
    t_pwm();
    t_async();
    complete_run();
  end
endmodule
